// file: verification/pmx_host_model.sv
// Purpose: Configuration host that issues classic Wishbone single cycles.
// Assumes: The slave answers with ack; no fixed latency is assumed here.
// Notes:   The bench calls xfer hierarchically; a hang is cut by its timeout.
`default_nettype none

module pmx_host_model
(
    input  wire logic        clk_i,  // Core clock.
    input  wire logic        ack_i,  // Slave acknowledge.
    input  wire logic [31:0] dat_i,  // Read data from the slave.
    output var  logic        cyc_o,  // Bus cycle.
    output var  logic        stb_o,  // Strobe.
    output var  logic        we_o,   // Write when high.
    output var  logic [11:0] adr_o,  // Byte address.
    output var  logic [3:0]  sel_o,  // Byte lanes.
    output var  logic [31:0] dat_o   // Write data.
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Idle bus at time zero
    // ------------------------------------------------------------------------
    initial
    begin
        {cyc_o, stb_o, we_o, sel_o} = 7'h00;
        adr_o = 12'h000;
        dat_o = 32'h0000_0000;
    end

    // One access: request held until ack is sampled high, then released.
    // Released address and data are inverted so stale values never pass.
    task automatic xfer(input logic we, input logic [11:0] adr, input logic [3:0] sel,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= adr;
        sel_o <= sel;
        dat_o <= wd;
        @(posedge clk_i);
        while (ack_i !== 1'b1)
        begin
            @(posedge clk_i);
        end
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~adr;
        dat_o <= ~wd;
    endtask : xfer

endmodule : pmx_host_model

`default_nettype wire

// file: verification/tb_pm_and_pcie_capability_regs.sv
// Purpose: Self-checking bench for the capability register bank.
// Assumes: Ack comes one cycle after the request; function reset shortened to 2.
// Notes:   Random write data from a fixed seed; expectations from exp_word.
`default_nettype none

`include "pmx_defines.svh"

module tb_pm_and_pcie_capability_regs
    import pmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // Build values chosen so every constant field except the next pointer is non-trivial
    // ------------------------------------------------------------------------
    localparam int         HOLD = 2;        // Short reset hold keeps the run brief.
    localparam logic [2:0] MPL  = 3'h1;     // 256-byte payload.
    localparam logic       NSR  = 1'b1;     // State kept across D3hot.
    localparam logic       FLRC = 1'b1;     // Function reset supported.
    localparam logic       ETAG = 1'b1;     // Extended tags.
    localparam logic [2:0] L0S  = 3'h5;     // L0s latency.
    localparam logic [2:0] L1   = 3'h2;     // L1 latency.
    localparam logic [7:0] NXT  = 8'h00;    // Last capability.

    logic        clk_i = 1'b0;   // Core clock.
    logic        rst_i = 1'b1;   // Reset.
    logic        cyc, stb, we, ack, d3, frst;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    pmx_pwr_t    pwr, p;         // Design state and bench model of it.
    int          errors = 0;     // Mismatches.
    int          n_checks = 0;   // Comparisons.
    int          seed = 32'h938E;
    int          cnt, tick = 0;
    logic [31:0] r;
    pmx_pwr_t    seq [5] = '{2'b11, 2'b01, 2'b00, 2'b10, 2'b11};

    always #2 clk_i = ~clk_i;

    pmx_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    pmx_cap_regs #(.MAX_PAYLOAD(MPL), .NO_SOFT_RST(NSR), .FLR_CAPABLE(FLRC),
        .EXT_TAG(ETAG), .L0S_LATENCY(L0S), .L1_LATENCY(L1), .EXP_NEXT_PTR(NXT),
        .FLR_HOLD(HOLD)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pwr_state_o(pwr), .d3hot_o(d3),
        .func_reset_o(frst));

    // Expected read value of any word for a given power state.
    function automatic logic [31:0] exp_word(input logic [11:0] a, input pmx_pwr_t s);
        case ({a[11:2], 2'b00})
            `PMX_OFF_PM_HDR:  exp_word = {13'h0, `PMX_PM_VERSION, `PMX_PM_NEXT_PTR, `PMX_PM_CAP_ID};
            `PMX_OFF_PM_CSR:  exp_word = {28'h0, NSR, 1'b0, s};
            `PMX_OFF_EXP_HDR: exp_word = {12'h0, `PMX_EXP_VERSION, NXT, `PMX_EXP_CAP_ID};
            `PMX_OFF_DEV_CAP: exp_word = {3'h0, FLRC, 12'h0, 1'b1, 3'h0, L1, L0S, ETAG, 2'h0, MPL};
            default:          exp_word = 32'h0000_0000;
        endcase
    endfunction : exp_word

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Counts cycles of function reset seen in the ten cycles after a write.
    task automatic count_reset(output int c);
        c = 0;
        repeat (10)
        begin
            @(negedge clk_i);
            if (frst === 1'b1) c++;
        end
    endtask : count_reset

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // Hang guard: the whole sequence needs well under a thousand cycles.
    always @(posedge clk_i)
    begin
        tick <= tick + 1;
        if (tick == 5000)
        begin
            errors++;
            test_done();
        end
    end

    initial
    begin
        p = 2'b00;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk({30'h0, pwr}, 32'h0000_0000);
        // Random writes then reads over the whole map and unmapped neighbours.
        for (int a = 12'h06C; a <= 12'h0B4; a += 4)
        begin
            r = $random(seed);
            if (a == 12'h088) r[15] = 1'b0;
            u_host.xfer(1'b1, a[11:0] | r[1:0], 4'hF, r, rd);
            if (a == 12'h07C && (r[1:0] == 2'b00 || r[1:0] == 2'b11)) p = r[1:0];
            u_host.xfer(1'b0, a[11:0], 4'hF, 32'h0, rd);
            chk(rd, exp_word(a[11:0], p));
        end
        // Every power-state encoding, legal and refused.
        foreach (seq[i])
        begin
            r = $random(seed);
            u_host.xfer(1'b1, `PMX_OFF_PM_CSR, 4'h1, {r[31:2], seq[i]}, rd);
            if (seq[i] == `PMX_PWR_D0 || seq[i] == `PMX_PWR_D3HOT) p = seq[i];
            @(negedge clk_i);
            chk({30'h0, pwr}, {30'h0, p});
            chk({31'h0, d3}, {31'h0, p == `PMX_PWR_D3HOT});
            u_host.xfer(1'b0, `PMX_OFF_PM_CSR, 4'h0, 32'h0, rd);
            chk(rd, exp_word(`PMX_OFF_PM_CSR, p));
        end
        // Lane 0 off: the state field must not move.
        u_host.xfer(1'b1, `PMX_OFF_PM_CSR, 4'hE, 32'h0000_0000, rd);
        @(negedge clk_i);
        chk({30'h0, pwr}, {30'h0, p});
        // Function reset from D3hot: held HOLD cycles, state back to D0.
        u_host.xfer(1'b1, `PMX_OFF_DEV_CTL, 4'h2, 32'h0000_8000, rd);
        count_reset(cnt);
        chk(cnt, HOLD);
        chk({30'h0, pwr}, 32'h0000_0000);
        // Reset bit without its lane does nothing; the word reads zero.
        u_host.xfer(1'b1, `PMX_OFF_DEV_CTL, 4'h1, 32'h0000_8000, rd);
        count_reset(cnt);
        chk(cnt, 0);
        u_host.xfer(1'b0, `PMX_OFF_DEV_CTL, 4'hF, 32'h0, rd);
        chk(rd, 32'h0000_0000);
        // Reset in mid-run from D3hot must bring the state back to D0.
        u_host.xfer(1'b1, `PMX_OFF_PM_CSR, 4'h1, 32'h0000_0003, rd);
        @(negedge clk_i);
        chk({31'h0, d3}, 32'h0000_0001);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        p = `PMX_PWR_D0;
        @(negedge clk_i);
        chk({30'h0, pwr}, {30'h0, p});
        u_host.xfer(1'b0, `PMX_OFF_PM_CSR, 4'hF, 32'h0, rd);
        chk(rd, exp_word(`PMX_OFF_PM_CSR, p));
        test_done();
    end

endmodule : tb_pm_and_pcie_capability_regs

`default_nettype wire

// file: verilog/pmx_cap_regs.sv
// Purpose: Power-management and express capability registers of one endpoint function.
// Assumes: Configuration software reaches the words over classic Wishbone.
// Notes:   Almost all fields are build-time constants; the power state is writable,
//          and a write to the reset-initiate bit of device control starts a
//          function-level reset when the function advertises that ability.
//
// Our own choice: the Wishbone slave port.
`default_nettype none

`include "pmx_defines.svh"

module pmx_cap_regs
    import pmx_pkg::*;
#(
    parameter logic [2:0] MAX_PAYLOAD  = 3'b000,   // Max payload: 000 or 001.
    parameter logic       NO_SOFT_RST  = 1'b0,     // State kept across D3hot.
    parameter logic       FLR_CAPABLE  = 1'b1,     // Function reset supported.
    parameter logic       EXT_TAG      = 1'b0,     // Extended tags supported.
    parameter logic [2:0] L0S_LATENCY  = 3'b000,   // Acceptable L0s latency.
    parameter logic [2:0] L1_LATENCY   = 3'b000,   // Acceptable L1 latency.
    parameter logic [7:0] EXP_NEXT_PTR = 8'h00,    // Next capability after express.
    parameter int         FLR_HOLD     = `PMX_FLR_HOLD_CYC  // Function reset length.
)
(
    input  wire logic                  clk_i,         // Core clock, 250 MHz.
    input  wire logic                  rst_i,         // Synchronous reset, active high.
    input  wire logic                  wb_cyc_i,      // Bus cycle.
    input  wire logic                  wb_stb_i,      // Strobe.
    input  wire logic                  wb_we_i,       // Write enable.
    input  wire logic [`PMX_ADR_W-1:0] wb_adr_i,      // Byte address.
    input  wire logic [3:0]            wb_sel_i,      // Byte lanes.
    input  wire logic [31:0]           wb_dat_i,      // Write data.
    output logic [31:0]                wb_dat_o,      // Read data.
    output logic                       wb_ack_o,      // Acknowledge.
    output logic [1:0]                 pwr_state_o,   // Current power state.
    output logic                       d3hot_o,       // Function is in D3hot.
    output logic                       func_reset_o   // Function-level reset level.
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Only the two payload sizes named for this function can be advertised,
    // and a reset held for no cycles would never reach the function.
    // Both are refused while the design is built, not at run time.
    if (MAX_PAYLOAD > 3'b001)
    begin : g_bad_payload
        $error("pmx_cap_regs: MAX_PAYLOAD must be 000 or 001");
    end
    if (FLR_HOLD < 1)
    begin : g_bad_hold
        $error("pmx_cap_regs: FLR_HOLD must be at least one");
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // True when the byte address falls in the word at the given offset.
    function automatic logic word_hit(input logic [`PMX_ADR_W-1:0] adr,
                                      input logic [`PMX_ADR_W-1:0] off);
        word_hit = (adr[`PMX_ADR_W-1:2] == off[`PMX_ADR_W-1:2]);
    endfunction : word_hit

    // True for the two power-state encodings this function supports.
    function automatic logic pwr_legal(input logic [1:0] v);
        pwr_legal = (v == `PMX_PWR_D0) || (v == `PMX_PWR_D3HOT);
    endfunction : pwr_legal

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic      rd_take;       // Capture read data this cycle.
    logic      wr_en;         // Commit a write this cycle.
    pmx_pwr_t  pwr_state_r;   // Power-state field.
    pmx_pwr_t  pwr_state_nxt; // Next power state.
    logic      flr_start;     // Pulse starting a function reset.
    logic      flr_active;    // Function reset in progress.
    logic [31:0] rd_word;     // Word selected for a read.
    logic [31:0] dat_r;       // Registered read data.
    logic [31:0] pm_hdr_word; // Power capability header value.
    logic [31:0] pm_csr_word; // Power control/status value.
    logic [31:0] exp_hdr_word;// Express capability header value.
    logic [31:0] dev_cap_word;// Device capabilities value.

    // ------------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------------
    // The slave answers every address, mapped or not, one cycle after the
    // request; unmapped words simply read zero so software never hangs.
    pmx_wb_slave u_wb
    (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_we_i   (wb_we_i),
        .wb_ack_o  (wb_ack_o),
        .rd_take_o (rd_take),
        .wr_en_o   (wr_en)
    );

    // ------------------------------------------------------------------------
    // Constant capability words
    // ------------------------------------------------------------------------
    // Power header: ID, next pointer and version are wired constants, so
    // writes have nothing to land in.
    always_comb
    begin
        pm_hdr_word        = `PMX_WORD_ZERO;
        pm_hdr_word[7:0]   = `PMX_PM_CAP_ID;
        pm_hdr_word[15:8]  = `PMX_PM_NEXT_PTR;
        pm_hdr_word[18:16] = `PMX_PM_VERSION;
    end

    // Control/status: state field plus the retention flag; bit 2 and all
    // upper bits stay zero.
    always_comb
    begin
        pm_csr_word               = `PMX_WORD_ZERO;
        pm_csr_word[1:0]          = pwr_state_r;
        pm_csr_word[`PMX_NSR_BIT] = NO_SOFT_RST;
    end

    // Express header: its own ID and version, not a copy of the power
    // header, otherwise software walking the list would loop forever.
    always_comb
    begin
        exp_hdr_word        = `PMX_WORD_ZERO;
        exp_hdr_word[7:0]   = `PMX_EXP_CAP_ID;
        exp_hdr_word[15:8]  = EXP_NEXT_PTR;
        exp_hdr_word[19:16] = `PMX_EXP_VERSION;
    end

    // Device capabilities: build-time fields; slot power limit stays zero.
    always_comb
    begin
        dev_cap_word                   = `PMX_WORD_ZERO;
        dev_cap_word[2:0]              = MAX_PAYLOAD;
        dev_cap_word[5]                = EXT_TAG;
        dev_cap_word[8:6]              = L0S_LATENCY;
        dev_cap_word[11:9]             = L1_LATENCY;
        dev_cap_word[`PMX_RBER_BIT]    = 1'b1;
        dev_cap_word[`PMX_FLR_CAP_BIT] = FLR_CAPABLE;
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Every other word of the express structure is reserved here and reads
    // zero, as does anything outside this block; device control reads zero
    // too because its only implemented bit is self-clearing.
    always_comb
    begin
        rd_word = `PMX_WORD_ZERO;
        if (word_hit(wb_adr_i, `PMX_OFF_PM_HDR))
            rd_word = pm_hdr_word;
        else if (word_hit(wb_adr_i, `PMX_OFF_PM_CSR))
            rd_word = pm_csr_word;
        else if (word_hit(wb_adr_i, `PMX_OFF_EXP_HDR))
            rd_word = exp_hdr_word;
        else if (word_hit(wb_adr_i, `PMX_OFF_DEV_CAP))
            rd_word = dev_cap_word;
    end

    // Read data is held in a flop so the bus sees a clean value with ack.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_r <= `PMX_WORD_ZERO;
        else if (rd_take)
            dat_r <= rd_word;
    end

    assign wb_dat_o = dat_r;

    // ------------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------------
    // Writes of an unsupported encoding are dropped so the field can never
    // show a state the function does not implement.
    always_comb
    begin
        pwr_state_nxt = pwr_state_r;
        if (flr_start || flr_active)
            pwr_state_nxt = `PMX_PWR_D0;
        else if (wr_en && wb_sel_i[0] && word_hit(wb_adr_i, `PMX_OFF_PM_CSR)
                 && pwr_legal(wb_dat_i[1:0]))
            pwr_state_nxt = wb_dat_i[1:0];
    end

    // Reset and function reset both return the function to D0.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            pwr_state_r <= `PMX_PWR_D0;
        else
            pwr_state_r <= pwr_state_nxt;
    end

    assign pwr_state_o = pwr_state_r;
    assign d3hot_o     = (pwr_state_r == `PMX_PWR_D3HOT);

    // ------------------------------------------------------------------------
    // Function-level reset
    // ------------------------------------------------------------------------
    // The initiate bit has no storage; a write of one only fires the reset
    // when the capability flag is built in.
    assign flr_start = FLR_CAPABLE && wr_en && wb_sel_i[1]
                       && word_hit(wb_adr_i, `PMX_OFF_DEV_CTL)
                       && wb_dat_i[`PMX_FLR_INIT_BIT];

    pmx_flr_gen #(
        .HOLD_CYC (FLR_HOLD)
    ) u_flr
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (flr_start),
        .active_o (flr_active)
    );

    assign func_reset_o = flr_active;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic rd_ack;   // Read answer on the bus this cycle.
    assign rd_ack = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;

    logic init_wr;  // Reset-initiate write lands this cycle.
    assign init_wr = wr_en && wb_sel_i[1] && word_hit(wb_adr_i, `PMX_OFF_DEV_CTL)
                     && wb_dat_i[`PMX_FLR_INIT_BIT];

    // Kept apart from the read mux so a decode slip there shows up here.
    logic mapped;   // Address hits one of the four implemented words.
    assign mapped = word_hit(wb_adr_i, `PMX_OFF_PM_HDR)
                    || word_hit(wb_adr_i, `PMX_OFF_PM_CSR)
                    || word_hit(wb_adr_i, `PMX_OFF_EXP_HDR)
                    || word_hit(wb_adr_i, `PMX_OFF_DEV_CAP);

    pm_header_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_PM_HDR)
        |-> wb_dat_o[7:0] == `PMX_PM_CAP_ID && wb_dat_o[31:19] == 13'h0)
        else $error("power header id or upper bits wrong");

    pm_version_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_PM_HDR)
        |-> wb_dat_o[18:16] == `PMX_PM_VERSION && wb_dat_o[15:8] == `PMX_PM_NEXT_PTR)
        else $error("power header version or pointer wrong");

    pwr_write_a: assert property (
        wr_en && wb_sel_i[0] && word_hit(wb_adr_i, `PMX_OFF_PM_CSR)
        && pwr_legal(wb_dat_i[1:0]) && !flr_active
        |=> pwr_state_o == $past(wb_dat_i[1:0]))
        else $error("legal power state write not taken");

    pwr_illegal_a: assert property (
        wr_en && word_hit(wb_adr_i, `PMX_OFF_PM_CSR) && !pwr_legal(wb_dat_i[1:0])
        |=> $stable(pwr_state_o))
        else $error("illegal power state write changed the field");

    csr_read_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_PM_CSR)
        |-> wb_dat_o[3] == NO_SOFT_RST && wb_dat_o[31:4] == 28'h0
            && wb_dat_o[2] == 1'b0 && wb_dat_o[1:0] == pwr_state_o)
        else $error("power control word reads wrong");

    dev_cap_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_DEV_CAP)
        |-> wb_dat_o[15] && wb_dat_o[27:18] == 10'h0
            && wb_dat_o[2:0] == MAX_PAYLOAD && wb_dat_o[28] == FLR_CAPABLE)
        else $error("device capabilities read wrong");

    flr_fire_a: assert property (
        flr_start |=> func_reset_o && pwr_state_o == 2'b00)
        else $error("function reset did not start");

    // The reset may start only from an initiate write, and only when capable.
    flr_blocked_a: assert property (
        $rose(func_reset_o) |-> FLR_CAPABLE && $past(init_wr))
        else $error("function reset without capability");

    reserved_zero_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_DEV_CTL) |-> wb_dat_o == 32'h0)
        else $error("device control word not zero");

    // Express header carries its own identity, not a power header copy.
    exp_header_a: assert property (
        rd_ack && word_hit(wb_adr_i, `PMX_OFF_EXP_HDR)
        |-> wb_dat_o[7:0] == `PMX_EXP_CAP_ID && wb_dat_o[15:8] == EXP_NEXT_PTR
            && wb_dat_o[19:16] == `PMX_EXP_VERSION && wb_dat_o[31:20] == 12'h000)
        else $error("express header reads wrong");

    // Only the two supported power states can ever be held.
    pwr_legal_a: assert property (
        pwr_legal(pwr_state_o))
        else $error("power state holds an unsupported encoding");

    // Words outside the four implemented ones read zero.
    unmapped_zero_a: assert property (
        rd_ack && !mapped |-> wb_dat_o == `PMX_WORD_ZERO)
        else $error("unmapped word not zero");

    // A request is answered exactly one cycle after it is taken.
    ack_next_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after the request");

    // While the function reset stands the function sits in D0.
    flr_d0_a: assert property (
        func_reset_o |-> pwr_state_o == `PMX_PWR_D0)
        else $error("power state not D0 during function reset");

    ack_single_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // Covers: each main scenario is reached at least once.

    d3_entry_c:  cover property (wr_en ##1 d3hot_o);
    unmapped_c:  cover property (rd_ack && !mapped);
    flr_seen_c:  cover property (flr_start ##1 func_reset_o);
    cap_read_c:  cover property (rd_ack && word_hit(wb_adr_i, `PMX_OFF_DEV_CAP));

endmodule : pmx_cap_regs

`default_nettype wire

// file: verilog/pmx_defines.svh
// Purpose: Offsets, field positions, constants and timing for the capability register bank.
// Assumes: A 12-bit byte address into configuration space and 32-bit data words.
// Notes:   Definitions only; included by its bare name.
`ifndef PMX_DEFINES_SVH
`define PMX_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PMX_ADR_W          12
`define PMX_OFF_PM_HDR     12'h078
`define PMX_OFF_PM_CSR     12'h07C
`define PMX_OFF_EXP_HDR    12'h080
`define PMX_OFF_DEV_CAP    12'h084
`define PMX_OFF_DEV_CTL    12'h088
`define PMX_OFF_EXP_LAST   12'h0B0

// ----------------------------------------------------------------------------
// Field values and positions
// ----------------------------------------------------------------------------
`define PMX_PM_CAP_ID      8'h01
`define PMX_PM_VERSION     3'h3
`define PMX_PM_NEXT_PTR    8'h80
`define PMX_EXP_CAP_ID     8'h10
`define PMX_EXP_VERSION    4'h2
`define PMX_PWR_D0         2'b00
`define PMX_PWR_D3HOT      2'b11
`define PMX_NSR_BIT        3
`define PMX_RBER_BIT       15
`define PMX_FLR_CAP_BIT    28
`define PMX_FLR_INIT_BIT   15
`define PMX_WORD_ZERO      32'h0000_0000

// ----------------------------------------------------------------------------
// Timing: how long the function-level reset is held
// ----------------------------------------------------------------------------
`define PMX_CLK_PERIOD_NS  4
`define PMX_FLR_HOLD_NS    100
`define PMX_FLR_HOLD_CYC   ((`PMX_FLR_HOLD_NS + `PMX_CLK_PERIOD_NS - 1) / `PMX_CLK_PERIOD_NS)

`endif

// file: verilog/pmx_flr_gen.sv
// Purpose: Stretches a function-level reset request into a held reset level.
// Assumes: start_i is a one-cycle pulse in the core clock domain.
// Notes:   A new start while active restarts the hold count.
`default_nettype none

module pmx_flr_gen
    import pmx_pkg::*;
#(
    parameter int HOLD_CYC = 25   // Cycles the function reset is held.
)
(
    input  wire logic clk_i,      // Core clock.
    input  wire logic rst_i,      // Synchronous reset, active high.
    input  wire logic start_i,    // Pulse: begin a function reset.
    output logic      active_o    // Level: function reset in progress.
);

    // ------------------------------------------------------------------------
    // Hold counter
    // ------------------------------------------------------------------------
    localparam int CW = $clog2(HOLD_CYC + 1);

    logic [CW-1:0] left_r;        // Cycles still to hold.

    // A hold of no cycles would never raise the reset; refuse it at build time.
    if (HOLD_CYC < 1)
    begin : g_bad_hold
        $error("pmx_flr_gen: HOLD_CYC must be at least one");
    end

    // Load on start, count down to zero, the reset stands while nonzero.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            left_r <= '0;
        else if (start_i)
            left_r <= CW'(HOLD_CYC);
        else if (left_r != '0)
            left_r <= left_r - CW'(1);
    end

    assign active_o = (left_r != '0);

endmodule : pmx_flr_gen

`default_nettype wire

// file: verilog/pmx_pkg.sv
// Purpose: Shared types of the capability register bank.
// Assumes: Constants live in pmx_defines.svh.
// Notes:   Types only.
`default_nettype none

package pmx_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    // Power-state field of the control/status word.
    typedef logic [1:0] pmx_pwr_t;

    // Bus slave handshake states.
    typedef enum logic {PMX_BUS_IDLE, PMX_BUS_ACK} pmx_bus_state_t;

endpackage : pmx_pkg

`default_nettype wire

// file: verilog/pmx_wb_slave.sv
// Purpose: Classic Wishbone slave handshake for the capability register bank.
// Assumes: Single classic cycles; the master holds its request until it sees ack.
// Notes:   Ack comes one cycle after the request and lasts exactly one cycle.
`default_nettype none

module pmx_wb_slave
    import pmx_pkg::*;
(
    input  wire logic clk_i,      // Core clock.
    input  wire logic rst_i,      // Synchronous reset, active high.
    input  wire logic wb_cyc_i,   // Bus cycle in progress.
    input  wire logic wb_stb_i,   // Strobe.
    input  wire logic wb_we_i,    // Write when high.
    output logic      wb_ack_o,   // One-cycle acknowledge.
    output logic      rd_take_o,  // Pulse: capture read data now.
    output logic      wr_en_o     // Pulse: commit the write at this edge.
);

    // ------------------------------------------------------------------------
    // Handshake state
    // ------------------------------------------------------------------------
    pmx_bus_state_t state_r;      // Idle or acknowledging.
    logic           req;          // A request is on the bus.

    assign req = wb_cyc_i && wb_stb_i;

    // The ack state lasts one cycle, so ack falls the cycle after it rose
    // even if the master is slow to release its request.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= PMX_BUS_IDLE;
        end
        else
        begin
            case (state_r)
                PMX_BUS_IDLE: state_r <= req ? PMX_BUS_ACK : PMX_BUS_IDLE;
                PMX_BUS_ACK:  state_r <= PMX_BUS_IDLE;
                default:      state_r <= PMX_BUS_IDLE;
            endcase
        end
    end

    assign wb_ack_o  = (state_r == PMX_BUS_ACK);
    // Read data is latched in the request's first cycle, ready with ack.
    assign rd_take_o = req && !wb_we_i && (state_r == PMX_BUS_IDLE);
    // Writes land at the edge where the master samples ack.
    assign wr_en_o   = req && wb_we_i && (state_r == PMX_BUS_ACK);

endmodule : pmx_wb_slave

`default_nettype wire
